// ### rtl/xtv_core.sv
// Shared extension-vector multiplexer with trap flags and vectoring
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module xtv_core (
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  input  wire xtv_pkg::xtv_bus_t   bus_i,
  output logic [15:0]              rd_data_o,
  input  wire logic [13:0]         src_evt_i,
  input  wire logic                sw_reset_i,
  input  wire logic                wdt_ovf_i,
  input  wire logic                nmi_i,
  input  wire logic                stack_overflow_i,
  input  wire logic                stack_underflow_i,
  input  wire logic [5:0]          cls_b_evt_i,
  input  wire logic                trap_ack_i,
  input  wire logic                trap_done_i,
  output logic [3:0]               shared_vector_o,
  output xtv_pkg::xtv_trap_t       trap_o,
  output logic                     irq_o
);
  xtv_pkg::xtv_mst_t st;
  xtv_pkg::xtv_mst_t next_st;
  logic [3:0][7:0] hit;
  logic [3:0]      xreq;
  logic [5:0]      ist_evt;
  logic [7:0]      fclr;
  logic [15:0]     tfr_set;
  logic [15:0]     tfr_clr;
  logic [5:0]      ist_clr;
  logic            trap_busy;
  logic            cls_a_any;

  function automatic logic sel_hit(input logic [3:0] a, input int unsigned v);
    return a == (xtv_pkg::OFS_SEL0 + 4'(v));
  endfunction

  // Fixed wiring of peripheral events onto each flag bit except bit 7 of vector 3
  generate
    for (genvar v = 0; v < xtv_pkg::NVEC; v++) begin : g_vec
      for (genvar b = 0; b < 8; b++) begin : g_bit
        localparam logic [4:0] MAP = xtv_pkg::src_of(v, b);
        assign hit[v][b] = MAP[4] & src_evt_i[MAP[3:0]]; // see RQ7 see RQ5
      end
    end
  endgenerate

  assign cls_a_any = nmi_i | stack_overflow_i | stack_underflow_i;

  always_comb begin
    next_st = st;
    fclr = 8'h00;
    for (int v = 0; v < xtv_pkg::NVEC; v++) begin
      fclr = 8'h00;
      if (bus_i.wr && sel_hit(bus_i.addr, v)) begin
        next_st.en[v] = bus_i.wdata[15:8]; // see RQ2
        fclr = bus_i.wdata[7:0];
      end
      // Set wins over a write-one clear in the same cycle
      next_st.flag[v] = (st.flag[v] & ~fclr) | hit[v]; // see RQ3 see RQ15
      xreq[v] = |(st.en[v] & st.flag[v]); // see RQ4
    end
    next_st.xreq = xreq;
    // Vectors are held back while a trap is serviced
    next_st.vec = xreq & {4{~trap_busy}}; // see RQ14

    tfr_set = 16'h0000;
    tfr_set[xtv_pkg::TFR_NMI] = nmi_i; // see RQ13
    tfr_set[xtv_pkg::TFR_STACK_OVERFLOW_FLAG] = stack_overflow_i;
    tfr_set[xtv_pkg::TFR_STACK_UNDERFLOW_FLAG] = stack_underflow_i;
    tfr_set[5:0] = cls_b_evt_i; // see RQ11
    tfr_clr = (bus_i.wr && bus_i.addr == xtv_pkg::OFS_TFR) ? bus_i.wdata : 16'h0000;
    next_st.trap_flag_register = (st.trap_flag_register & ~tfr_clr) | tfr_set;

    ist_evt = {|cls_b_evt_i, cls_a_any, xreq & ~st.xreq};
    ist_clr = (bus_i.wr && bus_i.addr == xtv_pkg::OFS_ISTAT) ? bus_i.wdata[5:0] : 6'h00;
    next_st.istat = (st.istat & ~ist_clr) | ist_evt;
    if (bus_i.wr && bus_i.addr == xtv_pkg::OFS_IMASK) begin
      next_st.imask = bus_i.wdata[5:0];
    end
    next_st.irq = |(next_st.istat & next_st.imask);

    // Read data stand only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (bus_i.rd) begin
      for (int v = 0; v < xtv_pkg::NVEC; v++) begin
        if (sel_hit(bus_i.addr, v)) begin
          next_st.rdata = {st.en[v], st.flag[v]}; // see RQ1
        end
      end
      case (bus_i.addr)
        xtv_pkg::OFS_TFR: begin
          next_st.rdata = st.trap_flag_register;
        end
        xtv_pkg::OFS_ISTAT: begin
          next_st.rdata = {10'h000, st.istat};
        end
        xtv_pkg::OFS_IMASK: begin
          next_st.rdata = {10'h000, st.imask};
        end
        xtv_pkg::OFS_TSTAT: begin
          next_st.rdata = {14'h0000, trap_o.req, trap_busy};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  xtv_trap_unit u_trap (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .reset_evt_i (sw_reset_i | wdt_ovf_i), // see RQ8
    .cls_a_evt_i ({nmi_i, stack_overflow_i, stack_underflow_i}), // see RQ9
    .cls_b_evt_i (|cls_b_evt_i), // see RQ10
    .ack_i       (trap_ack_i),
    .done_i      (trap_done_i),
    .trap_o      (trap_o),
    .busy_o      (trap_busy)
  );

  assign rd_data_o = st.rdata;
  assign shared_vector_o = st.vec;
  assign irq_o = st.irq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_flag_set_wins: assert property (src_evt_i[0] |=> st.flag[0][0] && st.flag[3][0]) // see RQ15
    else $error("event flag lost");
  a_flag_polled: assert property (src_evt_i[1] && st.en[1] == 8'h00 |=> // see RQ5
    st.flag[1][0] && !shared_vector_o[1]) else $error("masked flag not set");
  a_enable_gates: assert property (!trap_busy && |(st.en[2] & st.flag[2]) |=> // see RQ4
    shared_vector_o[2]) else $error("enabled source not forwarded");
  a_mask_blocks: assert property (!(|(st.en[2] & st.flag[2])) |=> !shared_vector_o[2]) // see RQ4
    else $error("masked source forwarded");
  a_pll_only_v3: assert property (src_evt_i == 14'h1000 && st.flag[2] == 8'h00 && // see RQ7
    !bus_i.wr |=> st.flag[2] == 8'h00 && st.flag[3][5]) else $error("clock loss misrouted");
  a_write_clears: assert property (bus_i.wr && bus_i.addr == 4'h0 && // see RQ15
    bus_i.wdata[7:0] == 8'hFF && src_evt_i == 14'h0000 |=> st.flag[0] == 8'h00)
    else $error("flag clear failed");
  a_trap_flagged: assert property (nmi_i |=> st.trap_flag_register[15]) else $error("trap flag missing"); // see RQ13
  a_class_b_flag: assert property (cls_b_evt_i[5] |=> st.trap_flag_register[5]) // see RQ11
    else $error("class B flag missing");
  a_trap_blocks: assert property (trap_busy |=> shared_vector_o == 4'h0) // see RQ14
    else $error("vector during trap");
  a_read_latency: assert property (bus_i.rd && bus_i.addr == 4'h4 |=> rd_data_o == $past(st.trap_flag_register))
    else $error("read data wrong");
  a_irq_level: assert property (|(st.istat & st.imask) |-> irq_o) else $error("irq missing");

  c_shared_req: cover property (shared_vector_o[3]);
  c_irq: cover property (irq_o);
  c_clear_race: cover property (bus_i.wr && bus_i.addr == 4'h0 && src_evt_i[0]);
endmodule
`default_nettype wire

// ### rtl/xtv_pkg.sv
// Constants, types and decode functions of the shared-vector and trap block
// Contract
// RQ1 - Four shared vectors, each with one 16-bit source-select register
// RQ2 - Select bits 15:8 are enables letting a source drive its vector
// RQ3 - Select bits 7:0 are flags recording that the source's event occurred
// RQ4 - A vector requests only for flagged sources whose enable is set
// RQ5 - Flags set on events even while the enable bit is clear
// RQ6 - Software reads the flag byte to find which sources caused a request
// RQ7 - Sources connect to vectors per the fixed source-to-vector map
// RQ8 - Resets branch to 00'0000h, trap number 00h, highest priority
// RQ9 - Class A traps: 0008h/02h, 0010h/04h, 0018h/06h, second priority
// RQ10 - All class B traps share 0028h and number 0Ah, lowest trap priority
// RQ11 - Six class B conditions, each with its own flag
// RQ12 - CPU priority level forced to 15 while any trap is serviced
// RQ13 - Each hardware trap sets its own bit in the trap flag register
// RQ14 - Traps pre-empt unless higher service runs; interrupts never pre-empt traps (the trap unit also holds a trap off while an equal-level service runs)
// RQ15 - Software clears flags by writing; a same-cycle event keeps the flag set
package xtv_pkg;
  localparam int NVEC = 4;
  localparam int NSRC = 14;
  localparam logic [3:0] OFS_SEL0  = 4'h0;
  localparam logic [3:0] OFS_TFR   = 4'h4;
  localparam logic [3:0] OFS_ISTAT = 4'h5;
  localparam logic [3:0] OFS_IMASK = 4'h6;
  localparam logic [3:0] OFS_TSTAT = 4'h7;
  localparam int TFR_NMI   = 15;
  localparam int TFR_STACK_OVERFLOW_FLAG = 14;
  localparam int TFR_STACK_UNDERFLOW_FLAG = 13;
  localparam logic [4:0] PEND_RST = 5'h10;
  localparam logic [3:0] ILVL_MAX = 4'hF;
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] VEC_NMI   = 24'h000008;
  localparam logic [23:0] VEC_STO   = 24'h000010;
  localparam logic [23:0] VEC_STU   = 24'h000018;
  localparam logic [23:0] VEC_B     = 24'h000028;
  localparam logic [7:0]  TN_RESET  = 8'h00;
  localparam logic [7:0]  TN_NMI    = 8'h02;
  localparam logic [7:0]  TN_STO    = 8'h04;
  localparam logic [7:0]  TN_STU    = 8'h06;
  localparam logic [7:0]  TN_B      = 8'h0A;
  // Source indices on src_evt_i
  localparam logic [3:0] SRC_FIRST_CAN_CONTROLLER = 4'h0;
  localparam logic [3:0] SRC_SECOND_CAN_CONTROLLER = 4'h1;
  localparam logic [3:0] SRC_I2RX = 4'h2;
  localparam logic [3:0] SRC_I2TX = 4'h3;
  localparam logic [3:0] SRC_I2ER = 4'h4;
  localparam logic [3:0] SRC_SSRX = 4'h5;
  localparam logic [3:0] SRC_SSTX = 4'h6;
  localparam logic [3:0] SRC_SSER = 4'h7;
  localparam logic [3:0] SRC_ASRX = 4'h8;
  localparam logic [3:0] SRC_ASTX = 4'h9;
  localparam logic [3:0] SRC_ASTB = 4'hA;
  localparam logic [3:0] SRC_ASER = 4'hB;
  localparam logic [3:0] SRC_PLL  = 4'hC;
  localparam logic [3:0] SRC_SECOND_PULSE_UNIT = 4'hD;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } xtv_bus_t;

  typedef struct packed {
    logic        req;
    logic [23:0] vector;
    logic [7:0]  number;
    logic        force_ilvl;
    logic [3:0]  ilvl;
  } xtv_trap_t;

  typedef struct packed {
    logic [4:0] pend;
    logic [2:0] active;
    logic [2:0] sel;
    logic       busy;
    xtv_trap_t  out;
  } xtv_tst_t;

  typedef struct packed {
    logic [3:0][7:0] en;
    logic [3:0][7:0] flag;
    logic [15:0]     trap_flag_register;
    logic [5:0]      istat;
    logic [5:0]      imask;
    logic [3:0]      xreq;
    logic [3:0]      vec;
    logic            irq;
    logic [15:0]     rdata;
  } xtv_mst_t;

  // Returns {valid, source index} for flag bit b of vector v
  function automatic logic [4:0] src_of(input int unsigned v, input int unsigned b);
    logic [3:0] com [7];
    com = '{SRC_I2RX, SRC_I2TX, SRC_SSRX, SRC_SSTX, SRC_ASRX, SRC_ASTX, SRC_ASTB};
    if (v == 3) begin
      case (b)
        0: return {1'b1, SRC_FIRST_CAN_CONTROLLER};
        1: return {1'b1, SRC_SECOND_CAN_CONTROLLER};
        2: return {1'b1, SRC_I2ER};
        3: return {1'b1, SRC_SSER};
        4: return {1'b1, SRC_ASER};
        5: return {1'b1, SRC_PLL};
        6: return {1'b1, SRC_SECOND_PULSE_UNIT};
        default: return 5'h00;
      endcase
    end
    if (b == 0) begin
      return (v == 0) ? {1'b1, SRC_FIRST_CAN_CONTROLLER} : (v == 1) ? {1'b1, SRC_SECOND_CAN_CONTROLLER} : {1'b1, SRC_SECOND_PULSE_UNIT};
    end
    return {1'b1, com[b-1]};
  endfunction

  // Trap selector: 4 reset, 3 NMI, 2 overflow, 1 underflow, 0 class B
  function automatic logic [2:0] lvl_of(input logic [2:0] s);
    return (s == 3'h4) ? 3'h4 : (s == 3'h0) ? 3'h1 : 3'h2;
  endfunction

  function automatic logic [23:0] vec_of(input logic [2:0] s);
    case (s)
      3'h4:    return VEC_RESET;
      3'h3:    return VEC_NMI;
      3'h2:    return VEC_STO;
      3'h1:    return VEC_STU;
      default: return VEC_B;
    endcase
  endfunction

  function automatic logic [7:0] tn_of(input logic [2:0] s);
    case (s)
      3'h4:    return TN_RESET;
      3'h3:    return TN_NMI;
      3'h2:    return TN_STO;
      3'h1:    return TN_STU;
      default: return TN_B;
    endcase
  endfunction
endpackage

// ### rtl/xtv_trap_unit.sv
// Hardware trap prioritiser and vector generator
`timescale 1ns/1ps
`default_nettype none
module xtv_trap_unit (
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic          reset_evt_i,
  input  wire logic [2:0]    cls_a_evt_i,
  input  wire logic          cls_b_evt_i,
  input  wire logic          ack_i,
  input  wire logic          done_i,
  output xtv_pkg::xtv_trap_t trap_o,
  output logic               busy_o
);
  xtv_pkg::xtv_tst_t st;
  xtv_pkg::xtv_tst_t next_st;
  logic [4:0] clr;
  logic [2:0] top;
  logic [2:0] pick;
  logic [2:0] act;

  always_comb begin
    next_st = st;
    clr = 5'h00;
    top = st.active[2] ? 3'h4 : (st.active[1] ? 3'h2 : st.active);
    act = st.active;
    if (done_i) begin
      act = act & ~top;
    end
    if (st.out.req && ack_i) begin
      clr[st.sel] = 1'b1;
      act = act | xtv_pkg::lvl_of(st.sel);
      next_st.out.req = 1'b0;
    end
    next_st.active = act;
    // A new event on the source being acknowledged stays pending
    next_st.pend = (st.pend & ~clr) | {reset_evt_i, cls_a_evt_i, cls_b_evt_i};
    if (st.pend[4]) begin
      pick = 3'h4;
    end else if (st.pend[3]) begin
      pick = 3'h3;
    end else if (st.pend[2]) begin
      pick = 3'h2;
    end else if (st.pend[1]) begin
      pick = 3'h1;
    end else begin
      pick = 3'h0;
    end
    // One-hot level above every active bit means strictly higher priority
    if (!st.out.req && (st.pend != 5'h00) && (xtv_pkg::lvl_of(pick) > st.active)) begin // see RQ14
      next_st.out.req = 1'b1;
      next_st.sel = pick;
      next_st.out.vector = xtv_pkg::vec_of(pick); // see RQ8 see RQ9 see RQ10
      next_st.out.number = xtv_pkg::tn_of(pick);
    end
    next_st.busy = |act;
    next_st.out.force_ilvl = |act; // see RQ12
    next_st.out.ilvl = (|act) ? xtv_pkg::ILVL_MAX : 4'h0;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.pend <= xtv_pkg::PEND_RST;
    end else begin
      st <= next_st;
    end
  end

  assign trap_o = st.out;
  assign busy_o = st.busy;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_reset_vector: assert property (trap_o.req && st.sel == 3'h4 |-> // see RQ8
    trap_o.vector == 24'h000000 && trap_o.number == 8'h00) else $error("reset vector wrong");
  a_class_b_shared: assert property (trap_o.req && st.sel == 3'h0 |-> // see RQ10
    trap_o.vector == 24'h000028 && trap_o.number == 8'h0A) else $error("class B vector wrong");
  a_ilvl_forced: assert property (trap_o.req && ack_i |=> trap_o.force_ilvl && // see RQ12
    trap_o.ilvl == 4'hF) else $error("priority level not forced");
  a_nmi_preempt: assert property (!st.out.req && st.pend[3] && !st.pend[4] && // see RQ9
    st.active[2:1] == 2'b00 |=> trap_o.req && trap_o.vector == 24'h000008)
    else $error("NMI did not pre-empt");
  a_no_lower_trap: assert property (st.active[1] && !st.out.req && !done_i |=> // see RQ14
    !(trap_o.req && st.sel == 3'h0)) else $error("class B entered during class A");
  c_trap_taken: cover property (trap_o.req && ack_i);
  c_nested: cover property (st.active == 3'h3);
endmodule
`default_nettype wire

// ### testbench/xtv_cpu_model.sv
// Behavioural CPU trap sequencer that takes trap requests and ends services
`timescale 1ns/1ps
`default_nettype none
module xtv_cpu_model (
  input  wire logic               clk_sys_i,
  input  wire logic               nrst_i,
  input  wire xtv_pkg::xtv_trap_t trap_i,
  input  wire logic               slow_i,
  output logic                    ack_o,
  output logic                    done_o
);
  int dly;
  int depth;
  int svc;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o  <= 1'b0;
      done_o <= 1'b0;
      dly    <= 0;
      depth  <= 0;
      svc    <= 0;
    end else begin
      ack_o  <= 1'b0;
      done_o <= 1'b0;
      // Ack only a standing request, once; slow mode stalls to widen races
      if (trap_i.req && !ack_o) begin
        dly <= dly + 1;
        if (dly >= (slow_i ? 3 : 0)) begin
          ack_o <= 1'b1;
          dly   <= 0;
          depth <= depth + 1;
          svc   <= 0;
        end
      end else if (depth > 0 && !done_o) begin
        // Innermost service ends first; outer ones resume afterwards
        svc <= svc + 1;
        if (svc == 5) begin
          done_o <= 1'b1;
          depth  <= depth - 1;
          svc    <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/xtv_core_bench.sv
// Self-checking bench of the shared-vector multiplexer and trap vectoring
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module xtv_core_bench;
  logic               clk_sys_i;
  logic               nrst_i;
  xtv_pkg::xtv_bus_t  bus_i;
  logic [15:0]        rd_data_o;
  logic [13:0]        src_evt_i;
  logic [10:0]        trp;
  logic               ack;
  logic               done;
  logic               slow;
  logic [3:0]         shared_vector_o;
  xtv_pkg::xtv_trap_t trap_o;
  logic               irq_o;
  logic               pr;
  logic               pf;
  logic [31:0]        e;
  logic [15:0]        d;
  logic [31:0]        exq[$];
  int                 miscompares;
  int                 checked;
  int                 en[4];
  int                 fl[4];
  int                 bmap[4][14];
  int                 com[7] = '{2, 3, 5, 6, 8, 9, 10};
  int                 v3s[7] = '{0, 1, 4, 7, 11, 12, 13};

  xtv_core xtv_core_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus_i),
    .rd_data_o(rd_data_o), .src_evt_i(src_evt_i), .sw_reset_i(trp[10]), .wdt_ovf_i(trp[9]),
    .nmi_i(trp[8]), .stack_overflow_i(trp[7]), .stack_underflow_i(trp[6]),
    .cls_b_evt_i(trp[5:0]), .trap_ack_i(ack), .trap_done_i(done),
    .shared_vector_o(shared_vector_o), .trap_o(trap_o), .irq_o(irq_o));
  xtv_cpu_model xtv_cpu_model_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .trap_i(trap_o),
    .slow_i(slow), .ack_o(ack), .done_o(done));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input logic [3:0] a, input logic [15:0] w, input logic wr,
                     input logic [13:0] s, input logic [10:0] t);
    @(posedge clk_sys_i);
    bus_i     <= '{a, w, wr, 1'b0};
    src_evt_i <= s;
    trp       <= t;
    @(posedge clk_sys_i);
    bus_i     <= '0;
    src_evt_i <= '0;
    trp       <= '0;
    if (wr && a < 4) begin
      en[a] = w[15:8];
      fl[a] &= ~w[7:0];
    end
    // Events land after the clearing write, so a same-cycle event wins
    for (int v = 0; v < 4; v++)
      for (int i = 0; i < 14; i++)
        if (s[i] && bmap[v][i] >= 0) fl[v] |= 1 << bmap[v][i];
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk_sys_i);
    bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1 q = rd_data_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic vchk;
    settle(1);
    for (int v = 0; v < 4; v++)
      `CHK("shared vector", (en[v] & fl[v]) != 0, shared_vector_o[v])
  endtask

  always @(posedge clk_sys_i) begin
    if (nrst_i && trap_o.req && !pr) begin
      e = (exq.size() > 0) ? exq.pop_front() : 32'hFFFFFFFF;
      `CHK("trap target", e, {trap_o.vector, trap_o.number})
    end
    if (nrst_i && trap_o.force_ilvl)
      `CHK("priority level", 4'hF, trap_o.ilvl)
    if (nrst_i && trap_o.force_ilvl && pf)
      `CHK("gated vectors", 4'h0, shared_vector_o)
    pr <= trap_o.req;
    pf <= trap_o.force_ilvl;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    nrst_i    = 1'b0;
    bus_i     = '0;
    src_evt_i = '0;
    trp       = '0;
    slow      = 1'b0;
    void'($urandom(32'hF4D60634));
    foreach (bmap[v, i]) bmap[v][i] = -1;
    for (int i = 0; i < 7; i++) begin
      bmap[0][com[i]] = i + 1;
      bmap[1][com[i]] = i + 1;
      bmap[2][com[i]] = i + 1;
      bmap[3][v3s[i]] = i;
    end
    bmap[0][0]  = 0;
    bmap[1][1]  = 0;
    bmap[2][13] = 0;
    exq.push_back({xtv_pkg::VEC_RESET, xtv_pkg::TN_RESET});
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // Reset request stands from the first edge after release, service not yet taken
    rd(4'h7, d);
    `CHK("trap status", 16'h0002, d)
    for (int v = 0; v < 4; v++) begin
      rd(4'(v), d);
      `CHK("select reset", 16'h0000, d)
    end
    settle(20);
    for (int n = 0; n < 80; n++) begin
      cyc(4'($urandom % 4), 16'($urandom), 1'($urandom % 2), 14'($urandom & $urandom), '0);
      vchk();
      rd(4'(n % 4), d);
      `CHK("select reg", {en[n % 4][7:0], fl[n % 4][7:0]}, d)
    end
    cyc(4'h0, 16'h00FF, 1'b1, 14'h0001, '0);
    rd(4'h0, d);
    `CHK("clear versus event", {en[0][7:0], fl[0][7:0]}, d)
    for (int v = 0; v < 4; v++) cyc(4'(v), 16'h00FF, 1'b1, '0, '0);
    vchk();
    // Clock loss alone, then a masked source: flags set, no vector raised
    cyc(4'h0, 16'h0000, 1'b0, 14'h1000, '0);
    cyc(4'h0, 16'h0000, 1'b0, 14'h0002, '0);
    vchk();
    for (int v = 1; v < 4; v++) begin
      rd(4'(v), d);
      `CHK("polled flags", {en[v][7:0], fl[v][7:0]}, d)
    end
    cyc(4'h9, 16'hFFFF, 1'b1, '0, '0);
    rd(4'h9, d);
    `CHK("unmapped read", 16'h0000, d)
    cyc(4'h6, 16'hFFFF, 1'b1, '0, '0);
    rd(4'h6, d);
    `CHK("mask read", 16'h003F, d)
    // A live request on vector 0 makes the trap-time gating observable
    cyc(4'h0, 16'h0100, 1'b1, 14'h0001, '0);
    vchk();
    cyc(4'h5, 16'h003F, 1'b1, '0, '0);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      cyc(4'h6, 16'h0020 & {16{i[0]}}, 1'b1, '0, 11'(1 << i));
      exq.push_back({xtv_pkg::VEC_B, xtv_pkg::TN_B});
      settle(25);
      `CHK("irq level", i[0], irq_o)
      rd(4'h4, d);
      `CHK("trap flags", 16'(1 << i), d)
      rd(4'h5, d);
      `CHK("event status", 16'h0020, d & 16'h0030)
      cyc(4'h4, 16'hFFFF, 1'b1, '0, '0);
      cyc(4'h5, 16'h003F, 1'b1, '0, '0);
      settle(2);
      `CHK("irq cleared", 1'b0, irq_o)
    end
    cyc(4'h0, 16'h0000, 1'b0, '0, 11'h1C1);
    exq.push_back({xtv_pkg::VEC_NMI, xtv_pkg::TN_NMI});
    exq.push_back({xtv_pkg::VEC_STO, xtv_pkg::TN_STO});
    exq.push_back({xtv_pkg::VEC_STU, xtv_pkg::TN_STU});
    exq.push_back({xtv_pkg::VEC_B, xtv_pkg::TN_B});
    settle(90);
    rd(4'h4, d);
    `CHK("class A flags", 16'hE001, d)
    for (int k = 0; k < 2; k++) begin
      cyc(4'h0, 16'h0000, 1'b0, '0, 11'h400 >> k);
      exq.push_back({xtv_pkg::VEC_RESET, xtv_pkg::TN_RESET});
      settle(30);
    end
    // Class A arriving mid class B service must pre-empt it
    cyc(4'h0, 16'h0000, 1'b0, '0, 11'h020);
    exq.push_back({xtv_pkg::VEC_B, xtv_pkg::TN_B});
    settle(6);
    cyc(4'h0, 16'h0000, 1'b0, '0, 11'h100);
    exq.push_back({xtv_pkg::VEC_NMI, xtv_pkg::TN_NMI});
    settle(60);
    `CHK("traps left", 0, exq.size())
    rd(4'h7, d);
    `CHK("trap idle", 16'h0000, d)
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
